// file: core/asof_top.sv
`timescale 1ns/1ps
// Overview of operation
// - samples are 14-bit two's complement, left-justified
// - registers show latest sample, else buffer head
// - burst order six bytes, fast read three
// - direct low-byte read returns low bits with buffer off
// - buffer on: 01h head, 02h-06h read zero
// - auto-increment walks status and six data bytes
// - high byte bits 13-6, low byte 5-0 shifted
// - mode: off, circular, stop, trigger
// - flush on disable, rate change, standby exit
// - disabling clears overflow, watermark and count
// - overflow flag set when count reaches 32
// - watermark flag when count >= nonzero watermark
// - trigger mode: watermark sets pretrigger depth
// - watermark never stops sample acceptance
// - samples enter at the system data rate
// - buffer read returns and removes oldest sample
// - partial entry read discards rest of entry
// - trigger: circular until event, then fill-stop
// - setup written in standby; watermark also active
// - sleep hold keeps contents, flags, blocks acquisition
module asof_top
  import asof_pkg::*;
#(
  parameter int DEPTH = ASOF_DEPTH,
  parameter int AW = ASOF_AW
)
(
  input wire logic clk,
  input wire logic rst,
  input wire asof_sample_t smp,
  input wire logic smp_stb,
  input wire logic sys_active,
  input wire logic sys_sleep,
  input wire logic fifo_gate_en,
  input wire logic fast_read,
  input wire logic trig_evt,
  input wire asof_req_t req,
  output logic [7:0] rdata_r,
  output logic rd_valid_r,
  output asof_stat_t stat_r,
  output logic [7:0] setup_r
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  asof_step_t step_r;
  asof_step_t step_nxt;
  logic act_q_r;
  logic slp_q_r;
  logic trig_r;
  logic ovf_r;
  logic wmrk_lvl;
  logic gate_r;
  logic new_r;
  asof_sample_t latest_r;
  asof_sample_t head;
  logic [ASOF_WORD_W-1:0] head_word;
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] rd_ptr_nxt;
  logic [AW:0] cnt;
  asof_mode_t mode;
  logic [5:0] wmrk;
  logic fifo_on;
  logic empty;
  logic full;
  logic active_rise;
  logic sleep_edge;
  logic gate_entry;
  logic flush;
  logic acq;
  logic at_cap;
  logic [AW:0] cap;
  logic push;
  logic drop;
  logic host_pop;
  logic pop_any;
  logic rd_head;
  logic last_byte;
  logic [7:0] rd_byte;
  logic [7:0] head_byte;
  logic setup_hit;
  asof_mode_t wr_mode;

  function automatic logic [7:0] hi_byte(input logic [ASOF_SMP_W-1:0] v);
    return v[ASOF_SMP_W-1:ASOF_LO_PAD*3];
  endfunction

  function automatic logic [7:0] lo_byte(input logic [ASOF_SMP_W-1:0] v);
    return {v[ASOF_LO_PAD*3-1:0], {ASOF_LO_PAD{1'b0}}};
  endfunction

  assign mode = asof_mode_t'(setup_r[ASOF_MODE_LSB+1:ASOF_MODE_LSB]);
  assign wmrk = setup_r[ASOF_WMRK_LSB+5:ASOF_WMRK_LSB];
  assign fifo_on = mode != ASOF_MODE_OFF;
  assign empty = cnt == '0;
  assign full = cnt == (AW+1)'(DEPTH);
  assign head = asof_sample_t'(head_word);

  //////////////////////////////////////////////////////////////////////////////
  // storage

  asof_level #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_level (
    .clk(clk),
    .rst(rst),
    .flush(flush),
    .push(push),
    .pop(pop_any),
    .wr_ptr_r(wr_ptr),
    .rd_ptr_r(rd_ptr),
    .rd_ptr_nxt(rd_ptr_nxt),
    .cnt_r(cnt)
  );

  asof_mem #(
    .W(ASOF_WORD_W),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .clk(clk),
    .we(push),
    .waddr(wr_ptr),
    .wdata(smp),
    .raddr(rd_ptr_nxt),
    .rdata_r(head_word)
  );

  //////////////////////////////////////////////////////////////////////////////
  // system state edges and flush

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      act_q_r <= 1'b0;
      slp_q_r <= 1'b0;
    end
    else
    begin
      act_q_r <= sys_active;
      slp_q_r <= sys_sleep;
    end
  end

  assign active_rise = sys_active && !act_q_r;
  assign sleep_edge = sys_sleep != slp_q_r;
  assign gate_entry = sys_sleep && !slp_q_r && fifo_gate_en && fifo_on;
  // a gated sleep entry keeps the contents, every other rate change flushes
  assign flush = !fifo_on || active_rise || (sleep_edge && !gate_entry);

  //////////////////////////////////////////////////////////////////////////////
  // acceptance per mode

  // strobe comes from the rate generator, already at the sleep or wake rate
  assign acq = smp_stb && sys_active && fifo_on && !gate_r && !flush;

  // before the trigger only the pretrigger depth is kept
  always_comb
  begin
    cap = (AW+1)'(DEPTH);
    if (mode == ASOF_MODE_TRIG && !trig_r && wmrk != '0 && wmrk < 6'(DEPTH))
    begin
      cap = (AW+1)'(wmrk);
    end
  end

  assign at_cap = cnt >= cap;

  // the watermark plays no part in acceptance
  always_comb
  begin
    push = 1'b0;
    drop = 1'b0;
    unique case (mode)
      ASOF_MODE_OFF:
      begin
        push = 1'b0;
      end
      ASOF_MODE_CIRC:
      begin
        push = acq;
        drop = acq && full;
      end
      ASOF_MODE_STOP:
      begin
        push = acq && !full;
      end
      ASOF_MODE_TRIG:
      begin
        push = trig_r ? (acq && !full) : acq;
        drop = acq && !trig_r && at_cap;
      end
    endcase
  end

  // a host pop and an oldest-drop in one cycle share the same single pop
  assign pop_any = host_pop || drop;

  always_ff @(posedge clk)
  begin
    if (rst || flush)
    begin
      trig_r <= 1'b0;
    end
    else if (trig_evt && mode == ASOF_MODE_TRIG)
    begin
      trig_r <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // flags

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ovf_r <= 1'b0;
    end
    else if (fifo_on && full)
    begin
      ovf_r <= 1'b1;
    end
    else if (flush)
    begin
      ovf_r <= 1'b0;
    end
  end

  // a level on the live count, so flag and count never disagree in the status byte
  assign wmrk_lvl = fifo_on && wmrk != '0 && cnt >= (AW+1)'(wmrk);

  // cleared once the buffer is empty or disabled; a new entry wins
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      gate_r <= 1'b0;
    end
    else if (gate_entry)
    begin
      gate_r <= 1'b1;
    end
    else if (!fifo_on || empty)
    begin
      gate_r <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stat_r <= '0;
    end
    else
    begin
      stat_r <= '{ovf: ovf_r, wmrk: wmrk_lvl, gate_err: gate_r, cnt: ASOF_CNT_W'(cnt)};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // latest sample path (buffer off)

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      latest_r <= '0;
    end
    else if (smp_stb && sys_active)
    begin
      latest_r <= smp;
    end
  end

  // new-sample bit; a sample in the clearing cycle wins
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      new_r <= 1'b0;
    end
    else if (smp_stb && sys_active)
    begin
      new_r <= 1'b1;
    end
    else if (req.rd && ptr_r == ASOF_ADDR_X_HIGH && !fifo_on)
    begin
      new_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // head entry byte stepping

  assign rd_head = req.rd && fifo_on && ptr_r == ASOF_ADDR_X_HIGH && !empty;
  assign last_byte = step_r == ASOF_STEP_ZL || (fast_read && step_r == ASOF_STEP_ZH);

  always_comb
  begin
    head_byte = 8'h00;
    step_nxt = step_r;
    unique case (step_r)
      ASOF_STEP_XH:
      begin
        head_byte = hi_byte(head.x);
        step_nxt = fast_read ? ASOF_STEP_YH : ASOF_STEP_XL;
      end
      ASOF_STEP_XL:
      begin
        head_byte = lo_byte(head.x);
        step_nxt = ASOF_STEP_YH;
      end
      ASOF_STEP_YH:
      begin
        head_byte = hi_byte(head.y);
        step_nxt = fast_read ? ASOF_STEP_ZH : ASOF_STEP_YL;
      end
      ASOF_STEP_YL:
      begin
        head_byte = lo_byte(head.y);
        step_nxt = ASOF_STEP_ZH;
      end
      ASOF_STEP_ZH:
      begin
        head_byte = hi_byte(head.z);
        step_nxt = fast_read ? ASOF_STEP_XH : ASOF_STEP_ZL;
      end
      ASOF_STEP_ZL:
      begin
        head_byte = lo_byte(head.z);
        step_nxt = ASOF_STEP_XH;
      end
    endcase
  end

  // an entry leaves the head after its last byte, or when the burst ends early
  assign host_pop = (rd_head && last_byte)
    || (req.stop && step_r != ASOF_STEP_XH && !empty);

  always_ff @(posedge clk)
  begin
    if (rst || flush || req.stop)
    begin
      step_r <= ASOF_STEP_XH;
    end
    else if (rd_head)
    begin
      step_r <= step_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register pointer and read data

  // in buffer mode the pointer parks on the head register
  always_comb
  begin
    ptr_nxt = ptr_r + 8'h01;
    if (fifo_on && ptr_r == ASOF_ADDR_X_HIGH)
    begin
      ptr_nxt = ptr_r;
    end
    else if (fast_read && (ptr_r == ASOF_ADDR_X_HIGH || ptr_r == ASOF_ADDR_Y_HIGH
             || ptr_r == ASOF_ADDR_Z_HIGH))
    begin
      ptr_nxt = ptr_r + 8'h02;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ptr_r <= ASOF_ADDR_STATUS;
    end
    else if (req.start)
    begin
      ptr_r <= req.addr;
    end
    else if (req.rd || req.wr)
    begin
      ptr_r <= ptr_nxt;
    end
  end

  always_comb
  begin
    rd_byte = 8'h00;
    unique case (ptr_r)
      ASOF_ADDR_STATUS:
      begin
        rd_byte = fifo_on ? {ovf_r, wmrk_lvl, ASOF_CNT_W'(cnt)} : {7'h00, new_r};
      end
      ASOF_ADDR_X_HIGH:
      begin
        rd_byte = fifo_on ? (empty ? 8'h00 : head_byte) : hi_byte(latest_r.x);
      end
      ASOF_ADDR_X_LOW:
      begin
        rd_byte = fifo_on ? 8'h00 : lo_byte(latest_r.x);
      end
      ASOF_ADDR_Y_HIGH:
      begin
        rd_byte = fifo_on ? 8'h00 : hi_byte(latest_r.y);
      end
      ASOF_ADDR_Y_LOW:
      begin
        rd_byte = fifo_on ? 8'h00 : lo_byte(latest_r.y);
      end
      ASOF_ADDR_Z_HIGH:
      begin
        rd_byte = fifo_on ? 8'h00 : hi_byte(latest_r.z);
      end
      ASOF_ADDR_Z_LOW:
      begin
        rd_byte = fifo_on ? 8'h00 : lo_byte(latest_r.z);
      end
      ASOF_ADDR_SETUP:
      begin
        rd_byte = setup_r;
      end
      default:
      begin
        rd_byte = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_r <= 8'h00;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rd_valid_r <= req.rd;
      if (req.rd)
      begin
        rdata_r <= rd_byte;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // setup register

  assign setup_hit = req.wr && ptr_r == ASOF_ADDR_SETUP;
  assign wr_mode = asof_mode_t'(req.wdata[ASOF_MODE_LSB+1:ASOF_MODE_LSB]);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      setup_r <= ASOF_SETUP_RST;
    end
    else if (setup_hit)
    begin
      // watermark may change while active, the mode only in standby
      setup_r[ASOF_WMRK_LSB+5:ASOF_WMRK_LSB] <=
        req.wdata[ASOF_WMRK_LSB+5:ASOF_WMRK_LSB];
      // a direct switch between two operating modes is ignored
      if (!sys_active
          && !(fifo_on && wr_mode != ASOF_MODE_OFF && wr_mode != mode))
      begin
        setup_r[ASOF_MODE_LSB+1:ASOF_MODE_LSB] <= wr_mode;
      end
    end
  end

endmodule

// file: core/asof_pkg.sv
package asof_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int ASOF_DEPTH = 32;
  localparam int ASOF_AW = 5;
  localparam int ASOF_SMP_W = 14;
  localparam int ASOF_CNT_W = 6;

  //////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] ASOF_ADDR_STATUS = 8'h00;
  localparam logic [7:0] ASOF_ADDR_X_HIGH = 8'h01;
  localparam logic [7:0] ASOF_ADDR_X_LOW = 8'h02;
  localparam logic [7:0] ASOF_ADDR_Y_HIGH = 8'h03;
  localparam logic [7:0] ASOF_ADDR_Y_LOW = 8'h04;
  localparam logic [7:0] ASOF_ADDR_Z_HIGH = 8'h05;
  localparam logic [7:0] ASOF_ADDR_Z_LOW = 8'h06;
  localparam logic [7:0] ASOF_ADDR_SETUP = 8'h09;

  //////////////////////////////////////////////////////////////////////////////
  // buffer_setup fields and reset value
  localparam int ASOF_MODE_LSB = 6;
  localparam int ASOF_WMRK_LSB = 0;
  localparam logic [7:0] ASOF_SETUP_RST = 8'h00;

  // status byte in buffer mode: overflow, watermark, count
  localparam int ASOF_ST_OVF_BIT = 7;
  localparam int ASOF_ST_WMRK_BIT = 6;

  // low byte: sample bits 5..0 sit in positions 7..2
  localparam int ASOF_LO_PAD = 2;

  typedef enum logic [1:0] {
    ASOF_MODE_OFF = 2'h0,
    ASOF_MODE_CIRC = 2'h1,
    ASOF_MODE_STOP = 2'h2,
    ASOF_MODE_TRIG = 2'h3
  } asof_mode_t;

  // byte position inside the head entry during a buffer read
  typedef enum logic [5:0] {
    ASOF_STEP_XH = 6'h01,
    ASOF_STEP_XL = 6'h02,
    ASOF_STEP_YH = 6'h04,
    ASOF_STEP_YL = 6'h08,
    ASOF_STEP_ZH = 6'h10,
    ASOF_STEP_ZL = 6'h20
  } asof_step_t;

  typedef struct packed {
    logic [ASOF_SMP_W-1:0] x;
    logic [ASOF_SMP_W-1:0] y;
    logic [ASOF_SMP_W-1:0] z;
  } asof_sample_t;

  localparam int ASOF_WORD_W = $bits(asof_sample_t);

  // one register access: start loads the pointer, rd/wr act at the pointer
  typedef struct packed {
    logic start;
    logic rd;
    logic wr;
    logic stop;
    logic [7:0] addr;
    logic [7:0] wdata;
  } asof_req_t;

  typedef struct packed {
    logic ovf;
    logic wmrk;
    logic gate_err;
    logic [ASOF_CNT_W-1:0] cnt;
  } asof_stat_t;

endpackage

// file: core/asof_mem.sv
`timescale 1ns/1ps
module asof_mem
  import asof_pkg::*;
#(
  parameter int W = ASOF_WORD_W,
  parameter int DEPTH = ASOF_DEPTH,
  parameter int AW = ASOF_AW
)
(
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata_r
);

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // bypass so a word written into an empty buffer is at the head at once
  always_ff @(posedge clk)
  begin
    if (we && waddr == raddr)
    begin
      rdata_r <= wdata;
    end
    else
    begin
      rdata_r <= mem[raddr];
    end
  end

endmodule

// file: core/asof_level.sv
`timescale 1ns/1ps
module asof_level
  import asof_pkg::*;
#(
  parameter int DEPTH = ASOF_DEPTH,
  parameter int AW = ASOF_AW
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic push,
  input wire logic pop,
  output logic [AW-1:0] wr_ptr_r,
  output logic [AW-1:0] rd_ptr_r,
  output logic [AW-1:0] rd_ptr_nxt,
  output logic [AW:0] cnt_r
);

  function automatic logic [AW-1:0] step_ptr(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1))
    begin
      return '0;
    end
    return p + AW'(1);
  endfunction

  logic do_pop;
  logic [AW:0] cnt_nxt;

  // never below zero, never above depth
  assign do_pop = pop && (cnt_r != '0 || push);

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (push && !do_pop && cnt_r != (AW+1)'(DEPTH))
    begin
      cnt_nxt = cnt_r + (AW+1)'(1);
    end
    else if (do_pop && !push)
    begin
      cnt_nxt = cnt_r - (AW+1)'(1);
    end
    rd_ptr_nxt = flush ? '0 : (do_pop ? step_ptr(rd_ptr_r) : rd_ptr_r);
  end

  always_ff @(posedge clk)
  begin
    if (rst || flush)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= step_ptr(wr_ptr_r);
      end
      rd_ptr_r <= rd_ptr_nxt;
      cnt_r <= cnt_nxt;
    end
  end

endmodule

// file: sim/asof_monitor.sv
`timescale 1ns/1ps
module asof_monitor
  import asof_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire asof_req_t req,
  input wire logic [7:0] rdata_r,
  input wire logic rd_valid_r,
  input wire asof_stat_t stat_r,
  input wire logic [7:0] setup_r,
  input wire logic sys_active
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////////
  sequence setup_held;
    $stable(setup_r) ##1 $stable(setup_r);
  endsequence
  sequence off_held;
    setup_r[7:6] == 2'h0 [*3];
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  rd_answer_a: assert property (req.rd |=> rd_valid_r)
    else $error("read got no answer");
  rd_quiet_a: assert property (!req.rd |=> !rd_valid_r)
    else $error("answer without read");
  rd_hold_a: assert property (!rd_valid_r && !$past(rst) |-> $stable(rdata_r))
    else $error("read data moved without read");
  cnt_cap_a: assert property (stat_r.cnt <= 6'h20)
    else $error("count above depth");
  ovf_full_a: assert property (
    stat_r.cnt == 6'h20 && setup_r[7:6] != 2'h0 |-> ##[0:2] stat_r.ovf)
    else $error("full buffer without overflow");
  off_clear_a: assert property (off_held |-> stat_r == '0)
    else $error("disabled buffer kept flags or count");
  wmrk_level_a: assert property (
    setup_held ##0 setup_r[7:6] inside {2'h1, 2'h2}
    |-> stat_r.wmrk == (setup_r[5:0] != 6'h00 && stat_r.cnt >= setup_r[5:0]))
    else $error("watermark flag wrong");
  mode_lock_a: assert property (
    sys_active && $past(sys_active) && !$past(rst) |-> $stable(setup_r[7:6]))
    else $error("mode changed while active");
  no_switch_a: assert property (
    $past(setup_r[7:6]) != 2'h0 && setup_r[7:6] != 2'h0
    && !$past(rst) |-> setup_r[7:6] == $past(setup_r[7:6]))
    else $error("mode switched between operating modes");
endmodule
bind asof_top asof_monitor i_mon (.clk(clk), .rst(rst), .req(req), .rdata_r(rdata_r),
  .rd_valid_r(rd_valid_r), .stat_r(stat_r), .setup_r(setup_r), .sys_active(sys_active));

// file: sim/asof_host.sv
`timescale 1ns/1ps
module asof_host
  import asof_pkg::*;
(
  input wire logic clk,
  output asof_req_t req
);
  initial req = '0;
  // idle address and data are inverted so a stale sample of them shows up as garbage
  task automatic put(input logic [3:0] k, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = {k, a, d};
    @(negedge clk);
    req = {4'h0, ~a, ~d};
  endtask
  // mode changes only in standby, and between operating modes always via 00h
  task automatic setup(input logic [7:0] v);
    put(4'h8, ASOF_ADDR_SETUP, 8'h00);
    put(4'h2, 8'h00, v);
    put(4'h1, 8'h00, 8'h00);
  endtask
endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import asof_pkg::*;
  logic clk, rst, smp_stb, sys_active, sys_sleep, fifo_gate_en, fast_read, trig_evt;
  asof_sample_t smp, s;
  asof_req_t req;
  logic [7:0] rdata_r, setup_r;
  logic rd_valid_r;
  asof_stat_t stat_r;
  int bad_count = 0;
  int checked = 0;
  logic [7:0] eq[$];
  asof_sample_t fq[$];
  logic [1:0] mode = 2'h0;
  int wm = 0;
  bit trig = 0;
  bit gate = 0;
  //////////////////////////////////////////////////////////////////////////////
  asof_top i_dut (.clk(clk), .rst(rst), .smp(smp), .smp_stb(smp_stb),
    .sys_active(sys_active), .sys_sleep(sys_sleep), .fifo_gate_en(fifo_gate_en),
    .fast_read(fast_read), .trig_evt(trig_evt), .req(req), .rdata_r(rdata_r),
    .rd_valid_r(rd_valid_r), .stat_r(stat_r), .setup_r(setup_r));
  asof_host u_host (.clk(clk), .req(req));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [8:0] sv, input logic [8:0] ev);
    checked++;
    if (sv !== ev)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, ev, sv);
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  function automatic logic [7:0] hb(input logic [13:0] v);
    return v[13:6];
  endfunction
  function automatic logic [7:0] lb(input logic [13:0] v);
    return {v[5:0], 2'b00};
  endfunction
  task rd(input logic [7:0] e);
    eq.push_back(e);
    u_host.put(4'h4, 8'h00, 8'h00);
  endtask
  task one(input logic [7:0] a, input logic [7:0] e);
    u_host.put(4'h8, a, 8'h00);
    rd(e);
    u_host.put(4'h1, 8'h00, 8'h00);
  endtask
  // the head entry is read whole; in off mode the latest sample stays put
  task rd_ent(input bit fr, input bit from0);
    fast_read = fr;
    s = fq[0];
    if (mode != 2'h0)
      void'(fq.pop_front());
    u_host.put(4'h8, from0 ? ASOF_ADDR_STATUS : ASOF_ADDR_X_HIGH, 8'h00);
    if (from0)
      rd(8'h01);
    rd(hb(s.x));
    if (!fr)
      rd(lb(s.x));
    rd(hb(s.y));
    if (!fr)
      rd(lb(s.y));
    rd(hb(s.z));
    if (!fr)
      rd(lb(s.z));
    u_host.put(4'h1, 8'h00, 8'h00);
  endtask
  task push(input int n);
    int d;
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk);
      s = asof_sample_t'(42'({$urandom(), $urandom()}));
      smp = s;
      smp_stb = 1'b1;
      d = (mode == 2'h3 && wm > 0 && wm < 32) ? wm : 32;
      if (mode == 2'h0)
        fq = '{s};
      else if (!gate && (mode == 2'h1 || (mode == 2'h3 && !trig)))
      begin
        if (fq.size() >= d)
          void'(fq.pop_front());
        fq.push_back(s);
      end
      else if (!gate && fq.size() < 32)
        fq.push_back(s);
      @(negedge clk);
      smp_stb = 1'b0;
    end
  endtask
  task cst(input logic o, input logic w, input logic g, input logic [5:0] c);
    repeat (3) @(negedge clk);
    chk("stat", stat_r, {o, w, g, c});
  endtask
  task set_up(input logic [7:0] v);
    u_host.setup(v);
    mode = v[7:6];
    wm = v[5:0];
    if (mode == 2'h0)
      fq.delete();
  endtask
  task go_active;
    @(negedge clk);
    sys_active = 1'b1;
    fq.delete();
    trig = 0;
    repeat (2) @(negedge clk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(negedge clk)
    if (rd_valid_r === 1'b1)
    begin
      if (eq.size() == 0)
        chk("unexpected read", 9'h001, 9'h000);
      else
        chk("rdata", rdata_r, eq.pop_front());
    end
  // a normal run takes some 800 cycles
  initial
  begin
    #400000;
    chk("timeout", 9'h001, 9'h000);
    report_and_stop();
  end
  initial
  begin
    void'($urandom(32'he509));
    {rst, smp_stb, sys_active, sys_sleep, fifo_gate_en, fast_read, trig_evt} = 7'h40;
    smp = '0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk("setup", setup_r, ASOF_SETUP_RST);
    chk("stat", stat_r, 9'h000);
    go_active();
    push(1);
    rd_ent(0, 1);
    fast_read = 1'b1;
    rd_ent(1, 0);
    one(ASOF_ADDR_Y_LOW, lb(fq[0].y));
    one(8'h0a, 8'h00);
    sys_active = 1'b0;
    set_up(8'h44);
    chk("setup", setup_r, 9'h044);
    one(ASOF_ADDR_SETUP, 8'h44);
    go_active();
    // watermark alone may be rewritten while active
    u_host.setup(8'h45);
    wm = 5;
    chk("setup", setup_r, 9'h045);
    fast_read = 1'b0;
    push(5);
    cst(0, 1, 0, 5);
    one(ASOF_ADDR_X_LOW, 8'h00);
    rd_ent(0, 0);
    s = fq.pop_front();
    one(ASOF_ADDR_X_HIGH, hb(s.x));
    rd_ent(0, 0);
    cst(0, 0, 0, 2);
    push(40);
    cst(1, 1, 0, 32);
    rd_ent(1, 0);
    fifo_gate_en = 1'b1;
    sys_sleep = 1'b1;
    gate = 1;
    push(2);
    cst(1, 1, 1, 31);
    sys_sleep = 1'b0;
    gate = 0;
    fq.delete();
    cst(0, 0, 0, 0);
    fifo_gate_en = 1'b0;
    sys_active = 1'b0;
    set_up(8'h00);
    set_up(8'h80);
    go_active();
    push(35);
    cst(1, 0, 0, 32);
    rd_ent(0, 0);
    repeat (31) rd_ent(1, 0);
    one(ASOF_ADDR_X_HIGH, 8'h00);
    cst(1, 0, 0, 0);
    sys_active = 1'b0;
    push(2);
    set_up(8'h00);
    cst(0, 0, 0, 0);
    set_up(8'hc3);
    go_active();
    push(5);
    repeat (3) @(negedge clk);
    chk("count", stat_r.cnt, 9'h003);
    trig_evt = 1'b1;
    trig = 1;
    @(negedge clk);
    trig_evt = 1'b0;
    push(40);
    repeat (3) @(negedge clk);
    chk("count", stat_r.cnt, 9'h020);
    rd_ent(0, 0);
    repeat (5) @(negedge clk);
    // every read that was asked for must have been answered
    chk("pending", 9'(eq.size()), 9'h000);
    report_and_stop();
  end
endmodule
